// ### hw/tws_if.sv
// Two-wire bus carrier: open-drain SCL and SDA with pull-ups.
// Assumes each party drives a line low only while its enable is low.
`timescale 1ns/1ps
interface tws_if;
    logic scl_out;
    logic scl_oe_n;
    logic sda_host_out;
    logic sda_host_oe_n;
    logic sda_dev_out;
    logic sda_dev_oe_n;
    logic scl;
    logic sda;

    // Wired-AND with pull-up
    assign scl = scl_oe_n | scl_out;
    assign sda = (sda_host_oe_n | sda_host_out) & (sda_dev_oe_n | sda_dev_out);

    modport dev (input scl, input sda, output sda_dev_out, output sda_dev_oe_n);
    modport host (input scl, input sda, output scl_out, output scl_oe_n, output sda_host_out, output sda_host_oe_n);
endinterface

// ### hw/tws_master.sv
// Host end of the two-wire link: bus master making SCL by a divider.
// Assumes the user feeds write bytes on demand; SDA sampled via two flops.
`timescale 1ns/1ps
module tws_master (
    input wire logic mclk,
    input wire logic sys_rst,
    tws_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [6:0] cmd_addr,
    input wire logic cmd_read,
    input wire logic [3:0] cmd_len,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic nack,
    output logic done
);
    typedef struct packed {
        logic [1:0] sda_s;
        tws_pkg::tws_mst_e st;
        logic [1:0] q;
        logic [4:0] div;
        logic [3:0] bitn;
        logic [3:0] byten;
        logic [3:0] len;
        logic rd;
        logic [7:0] sh;
        logic scl_drv;
        logic sda_drv;
        logic [7:0] rd_data;
        logic rd_valid;
        logic nack;
        logic done;
    } tws_mst_s;

    tws_mst_s r;
    tws_mst_s n;
    logic tick;
    logic xmit;

    always_comb begin
        n = r;
        n.rd_valid = 1'b0;
        n.done = 1'b0;
        n.sda_s = {r.sda_s[0], bus.sda};
        tick = (r.div == 5'h00);
        n.div = tick ? tws_pkg::QUART_CYC - 5'h01 : r.div - 5'h01;
        xmit = (r.byten == 4'h0) || (r.rd == tws_pkg::DIR_WRITE);
        unique case (r.st)
            tws_pkg::MS_IDLE: begin
                n.scl_drv = 1'b0;
                n.sda_drv = 1'b0;
                if (cmd_valid) begin
                    n.sh = {cmd_addr, cmd_read};
                    n.rd = cmd_read;
                    n.len = (cmd_len > tws_pkg::MAX_BYTES) ? tws_pkg::MAX_BYTES : cmd_len;
                    n.byten = 4'h0;
                    n.bitn = 4'h0;
                    n.q = 2'h0;
                    n.nack = 1'b0;
                    n.div = tws_pkg::QUART_CYC - 5'h01;
                    n.st = tws_pkg::MS_START;
                end
            end
            tws_pkg::MS_START: begin
                if (tick) begin
                    if (r.q == 2'h0) begin
                        n.sda_drv = 1'b1;
                        n.q = 2'h1;
                    end else begin
                        n.scl_drv = 1'b1;
                        n.q = 2'h0;
                        n.st = tws_pkg::MS_BIT;
                    end
                end
            end
            tws_pkg::MS_LOAD: begin
                n.q = 2'h0;
                n.bitn = 4'h0;
                if (r.rd == tws_pkg::DIR_READ) begin
                    n.sh = 8'h00;
                    n.st = tws_pkg::MS_BIT;
                end else if (wr_valid) begin
                    n.sh = wr_data;
                    n.st = tws_pkg::MS_BIT;
                end
            end
            tws_pkg::MS_BIT: begin
                if (tick) begin
                    n.q = r.q + 2'h1;
                    unique case (r.q)
                        2'h0: begin
                            if (r.bitn < tws_pkg::BYTE_BITS) begin
                                n.sda_drv = xmit & ~r.sh[7];
                            end else begin
                                n.sda_drv = ~xmit && (r.byten != r.len);
                            end
                        end
                        2'h1: n.scl_drv = 1'b0;
                        2'h2: begin
                            if (r.bitn < tws_pkg::BYTE_BITS) begin
                                n.sh = {r.sh[6:0], r.sda_s[1]};
                            end else if (xmit && r.sda_s[1]) begin
                                n.nack = 1'b1;
                            end
                        end
                        2'h3: begin
                            n.scl_drv = 1'b1;
                            if (r.bitn == tws_pkg::BYTE_BITS) begin
                                n.sda_drv = 1'b0;
                                if (!xmit) begin
                                    n.rd_data = r.sh;
                                    n.rd_valid = 1'b1;
                                end
                                if (r.nack || r.byten == r.len) begin
                                    n.st = tws_pkg::MS_STOP;
                                end else begin
                                    n.byten = r.byten + 4'h1;
                                    n.st = tws_pkg::MS_LOAD;
                                end
                            end else begin
                                n.bitn = r.bitn + 4'h1;
                            end
                        end
                    endcase
                end
            end
            tws_pkg::MS_STOP: begin
                if (tick) begin
                    n.q = r.q + 2'h1;
                    if (r.q == 2'h0) begin
                        n.sda_drv = 1'b1;
                    end else if (r.q == 2'h1) begin
                        n.scl_drv = 1'b0;
                    end else begin
                        n.sda_drv = 1'b0;
                        n.done = 1'b1;
                        n.st = tws_pkg::MS_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r <= '{sda_s: 2'h3, st: tws_pkg::MS_IDLE, default: '0};
        end else begin
            r <= n;
        end
    end

    assign cmd_ready = (r.st == tws_pkg::MS_IDLE);
    assign wr_ready = (r.st == tws_pkg::MS_LOAD) && (r.rd == tws_pkg::DIR_WRITE);
    assign bus.scl_out = 1'b0;
    assign bus.scl_oe_n = ~r.scl_drv;
    assign bus.sda_host_out = 1'b0;
    assign bus.sda_host_oe_n = ~r.sda_drv;
    assign rd_data = r.rd_data;
    assign rd_valid = r.rd_valid;
    assign nack = r.nack;
    assign done = r.done;
endmodule // tws_master

// ### hw/tws_pkg.sv
// Shared constants and types of the two-wire serial link ends.
// Assumes a single 20 MHz system clock on both ends.
package tws_pkg;
    localparam int CLK_NS = 50;
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] FILT_CYC = 2'(SPIKE_CYC + 1);
    localparam int QUART_NS = 750;
    localparam logic [4:0] QUART_CYC = 5'((QUART_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] ADDR_FIXED = 2'h3;
    localparam logic [6:0] GCALL_ADDR = 7'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] MAX_BYTES = 4'h8;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 32;

    typedef enum logic [2:0] {
        DS_IDLE, DS_ADDR, DS_AACK, DS_WRB, DS_WACK, DS_RDB, DS_RACK, DS_IGNORE
    } tws_dst_e;

    typedef enum logic [2:0] {
        MS_IDLE, MS_START, MS_LOAD, MS_BIT, MS_STOP
    } tws_mst_e;
endpackage

// ### hw/tws_slave.sv
// Device end of the two-wire link: receive FIFO and slave engine.
// Assumes an external master clocks SCL; pins are asynchronous to mclk.
//
// Functional notes
// - Release both lines when idle.
// - Filter out spikes up to 50 ns.
// - SDA fall with SCL high starts datagram.
// - SDA rise with SCL high ends datagram.
// - Master alone drives SCL.
// - Change SDA only while SCL low.
// - Sample SDA on SCL rising edge.
// - Bytes are eight bits, MSB first.
// - Master sends at most eight bytes.
// - Receiver acknowledges every byte; slave nacks data when FIFO full or past eight bytes.
// - Address is 11, stored bits, pin bit.
// - Also answer general-call address zero.
// - Start, address, direction, ack, data, stop.
// - Acknowledge received bytes by pulling SDA low.
// - Master ends each transfer with stop.
// - Accept two-byte and eight-byte writes.
// - Read needs pointer write then read datagram.
// - Store pointer, use it for reads.
// - Shift read bytes, master acks each; tws_master leaves the last read byte unacknowledged.
// - Missing master ack ends read, release SDA.
`timescale 1ns/1ps

module tws_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } tws_fifo_s;
    tws_fifo_s r;
    tws_fifo_s n;
    logic full;
    logic empty;

    assign full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
    assign empty = (r.wp == r.rp);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = r.mem[r.rp[AW-1:0]];

    always_comb begin
        n = r;
        if (in_valid && !full) begin
            n.mem[r.wp[AW-1:0]] = in_data;
            n.wp = r.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            n.rp = r.rp + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule // tws_fifo

module tws_slave (
    input wire logic mclk,
    input wire logic sys_rst,
    tws_if.dev bus,
    input wire logic stored_address_bit3,
    input wire logic stored_address_bit2,
    input wire logic stored_address_bit1,
    input wire logic stored_address_bit0,
    input wire logic address_select_pin,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [7:0] reg_ptr,
    input wire logic [7:0] rd_byte,
    output logic rd_next,
    output logic gcall_seen,
    output logic in_datagram
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] hw_s;
        logic scl_f;
        logic sda_f;
        logic [1:0] scl_c;
        logic [1:0] sda_c;
        tws_pkg::tws_dst_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic [3:0] nbytes;
        logic drv;
        logic mack;
        logic gcall;
        logic [7:0] ptr;
        logic push;
        logic [7:0] pdata;
        logic rd_next;
    } tws_dev_s;

    tws_dev_s r;
    tws_dev_s n;
    logic fifo_in_ready;
    logic [6:0] own_addr;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;

    // Input deglitch: a change must persist for FILT_CYC samples
    function automatic logic [2:0] deglitch(input logic f, input logic raw, input logic [1:0] c);
        logic [2:0] res;
        res = {f, 2'h0};
        if (raw != f) begin
            if (c == tws_pkg::FILT_CYC - 2'h1) begin
                res = {raw, 2'h0};
            end else begin
                res = {f, c + 2'h1};
            end
        end
        return res;
    endfunction

    // Own address from fixed bits, stored bits and the strap pin
    assign own_addr = {tws_pkg::ADDR_FIXED, stored_address_bit3, stored_address_bit2,
                       stored_address_bit1, stored_address_bit0, r.hw_s[1]};

    always_comb begin
        n = r;
        n.push = 1'b0;
        n.rd_next = 1'b0;
        n.scl_s = {r.scl_s[0], bus.scl};
        n.sda_s = {r.sda_s[0], bus.sda};
        n.hw_s = {r.hw_s[0], address_select_pin};
        {n.scl_f, n.scl_c} = deglitch(r.scl_f, r.scl_s[1], r.scl_c);
        {n.sda_f, n.sda_c} = deglitch(r.sda_f, r.sda_s[1], r.sda_c);
        rise = n.scl_f & ~r.scl_f;
        fall = ~n.scl_f & r.scl_f;
        start_c = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
        stop_c = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;
        if (start_c) begin
            n.st = tws_pkg::DS_ADDR;
            n.cnt = 4'h0;
            n.sh = 8'h00;
            n.nbytes = 4'h0;
            n.drv = 1'b0;
        end else if (stop_c) begin
            n.st = tws_pkg::DS_IDLE;
            n.drv = 1'b0;
        end else begin
            unique case (r.st)
                tws_pkg::DS_IDLE, tws_pkg::DS_IGNORE: begin
                    n.drv = 1'b0;
                end
                tws_pkg::DS_ADDR, tws_pkg::DS_WRB: begin
                    if (rise) begin
                        n.sh = {r.sh[6:0], r.sda_f};
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (fall && r.cnt == tws_pkg::BYTE_BITS) begin
                        if (r.st == tws_pkg::DS_ADDR) begin
                            if (r.sh[7:1] == own_addr || r.sh[7:1] == tws_pkg::GCALL_ADDR) begin
                                n.drv = 1'b1;
                                n.rw = r.sh[0];
                                n.gcall = (r.sh[7:1] == tws_pkg::GCALL_ADDR);
                                n.st = tws_pkg::DS_AACK;
                            end else begin
                                n.st = tws_pkg::DS_IGNORE;
                            end
                        end else if (r.nbytes < tws_pkg::MAX_BYTES && fifo_in_ready) begin
                            n.drv = 1'b1;
                            n.push = 1'b1;
                            n.pdata = r.sh;
                            if (r.nbytes == 4'h0) begin
                                n.ptr = r.sh;
                            end
                            n.nbytes = r.nbytes + 4'h1;
                            n.st = tws_pkg::DS_WACK;
                        end else begin
                            n.st = tws_pkg::DS_IGNORE;
                        end
                    end
                end
                tws_pkg::DS_AACK, tws_pkg::DS_WACK: begin
                    if (fall) begin
                        n.cnt = 4'h0;
                        if (r.st == tws_pkg::DS_AACK && r.rw == tws_pkg::DIR_READ) begin
                            n.sh = rd_byte;
                            n.drv = ~rd_byte[7];
                            n.rd_next = 1'b1;
                            n.ptr = r.ptr + 8'h01;
                            n.st = tws_pkg::DS_RDB;
                        end else begin
                            n.drv = 1'b0;
                            n.st = tws_pkg::DS_WRB;
                        end
                    end
                end
                tws_pkg::DS_RDB: begin
                    if (rise) begin
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (fall) begin
                        if (r.cnt == tws_pkg::BYTE_BITS) begin
                            n.drv = 1'b0;
                            n.st = tws_pkg::DS_RACK;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.drv = ~r.sh[6];
                        end
                    end
                end
                tws_pkg::DS_RACK: begin
                    if (rise) begin
                        n.mack = ~r.sda_f;
                    end
                    if (fall) begin
                        n.cnt = 4'h0;
                        if (r.mack) begin
                            n.sh = rd_byte;
                            n.drv = ~rd_byte[7];
                            n.rd_next = 1'b1;
                            n.ptr = r.ptr + 8'h01;
                            n.st = tws_pkg::DS_RDB;
                        end else begin
                            n.drv = 1'b0;
                            n.st = tws_pkg::DS_IGNORE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r <= '{scl_s: 2'h3, sda_s: 2'h3, hw_s: 2'h0, scl_f: 1'b1, sda_f: 1'b1,
                   st: tws_pkg::DS_IDLE, default: '0};
        end else begin
            r <= n;
        end
    end

    tws_fifo #(.W(tws_pkg::FIFO_W), .D(tws_pkg::FIFO_D)) u_rx_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_data(r.pdata),
        .in_valid(r.push),
        .in_ready(fifo_in_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // Open drain: SDA only ever pulled low, SCL never driven
    assign bus.sda_dev_out = 1'b0;
    assign bus.sda_dev_oe_n = ~r.drv;
    assign reg_ptr = r.ptr;
    assign rd_next = r.rd_next;
    assign gcall_seen = r.gcall;
    assign in_datagram = (r.st != tws_pkg::DS_IDLE);
endmodule // tws_slave

// ### testbench/two_wire_serial_slave_test.sv
// Bench joining the master and slave ends over the two-wire carrier.
// Assumes design files compiled before it; stimulus from a fixed seed.
`timescale 1ns/1ps
module two_wire_serial_slave_test;
    logic mclk, sys_rst, hold, taken, address_select_pin;
    logic cmd_valid, cmd_ready, cmd_read, wr_valid, wr_ready, rd_valid, nack, done;
    logic rx_valid, rx_ready, rd_next, gcall_seen, in_datagram;
    logic [3:0] st, cmd_len;
    logic [6:0] cmd_addr, dev;
    logic [7:0] wr_data, rd_data, rx_data, reg_ptr, rd_byte;
    logic [7:0] wq [0:8];
    logic [7:0] rq [$], eq [$], gq [$];
    logic bq [$];
    int seed, bad_count, n_tests, cyc, i, nld;

    tws_if tws_if_inst();
    tws_slave tws_slave_inst(.mclk, .sys_rst, .bus(tws_if_inst.dev), .stored_address_bit3(st[3]),
        .stored_address_bit2(st[2]), .stored_address_bit1(st[1]), .stored_address_bit0(st[0]),
        .address_select_pin, .rx_data, .rx_valid, .rx_ready, .reg_ptr, .rd_byte, .rd_next, .gcall_seen,
        .in_datagram);
    tws_master tws_master_inst(.mclk, .sys_rst, .bus(tws_if_inst.host), .cmd_valid, .cmd_ready, .cmd_addr,
        .cmd_read, .cmd_len, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid, .nack, .done);
    tws_checker tws_checker_inst(.mclk(mclk), .sys_rst(sys_rst), .scl_out(tws_if_inst.scl_out),
        .scl_oe_n(tws_if_inst.scl_oe_n), .sda_host_out(tws_if_inst.sda_host_out),
        .sda_host_oe_n(tws_if_inst.sda_host_oe_n), .sda_dev_out(tws_if_inst.sda_dev_out),
        .sda_dev_oe_n(tws_if_inst.sda_dev_oe_n), .scl(tws_if_inst.scl), .sda(tws_if_inst.sda));

    // Register file seen by the slave: byte value tied to its pointer
    function automatic logic [7:0] exp_rd(input logic [7:0] p);
        return {p[3:0], p[7:4]} ^ 8'ha5;
    endfunction
    assign rd_byte = exp_rd(reg_ptr);
    assign dev = {tws_pkg::ADDR_FIXED, st, address_select_pin};

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        taken <= wr_valid && wr_ready;
        rx_ready <= #2 !hold && ($random(seed) % 4 != 0);
        if (rx_valid === 1'b1 && rx_ready === 1'b1) gq.push_back(rx_data);
        if (rd_next === 1'b1) nld++;
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            conclude();
        end
    end

    // Bits as seen on the wire at each clock rise
    always @(posedge tws_if_inst.scl) bq.push_back(tws_if_inst.sda);

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic xfer(input logic [6:0] a, input logic rd, input logic [3:0] len, input logic acc,
                        input logic nk);
        int k;
        int w;
        logic [7:0] b;
        w = 0;
        rq = {};
        bq = {};
        cmd_addr = a;
        cmd_read = rd;
        cmd_len = len;
        cmd_valid = 1'b1;
        wr_data = wq[0];
        wr_valid = !rd && len != 4'h0;
        @(posedge mclk);
        #2;
        cmd_valid = 1'b0;
        for (k = 0; k < 6000 && done !== 1'b1; k++) begin
            @(posedge mclk);
            #2;
            if (taken) begin
                w++;
                wr_data = wq[w];
                wr_valid = w < len;
            end
            if (rd_valid === 1'b1) rq.push_back(rd_data);
        end
        wr_valid = 1'b0;
        b = 8'h00;
        for (k = 0; k < 8; k++) b = {b[6:0], bq[k]};
        check("first byte", b, {a, rd});
        check("address ack", {7'h00, bq[8]}, {7'h00, !acc});
        check("nack", {7'h00, nack}, {7'h00, nk});
        repeat (8) @(posedge mclk);
        #2;
        check("idle lines", {6'h00, tws_if_inst.scl, tws_if_inst.sda}, 8'h03);
        check("in datagram", {7'h00, in_datagram}, 8'h00);
        check("cmd ready", {7'h00, cmd_ready}, 8'h01);
    endtask

    task automatic wr(input logic [6:0] a, input logic [3:0] len, input logic acc, input logic nk);
        int k;
        for (k = 0; k < 9; k++) wq[k] = 8'($random(seed));
        xfer(a, 1'b0, len, acc, nk);
        for (k = 0; k < len && k < 8 && acc && !nk; k++) eq.push_back(wq[k]);
        // Stop adds one clock rise after the last acknowledge
        if (acc && !nk) check("bit count", 8'(bq.size()), 8'(9 * (len > 4'h8 ? 9 : len + 1) + 1));
    endtask

    task automatic rdp(input logic [7:0] p, input logic [3:0] n);
        int k;
        wq[0] = p;
        xfer(dev, 1'b0, 4'h1, 1'b1, 1'b0);
        eq.push_back(p);
        nld = 0;
        xfer(dev, 1'b1, n, 1'b1, 1'b0);
        check("read count", 8'(rq.size()), 8'(n));
        check("load pulses", 8'(nld), 8'(n));
        for (k = 0; k < n; k++) check("read byte", rq[k], exp_rd(8'(p + k)));
        check("pointer", reg_ptr, 8'(p + n));
    endtask

    task automatic cmpq;
        int k;
        for (k = 0; k < 3000 && gq.size() < eq.size(); k++) @(posedge mclk);
        #2;
        check("fifo count", 8'(gq.size()), 8'(eq.size()));
        for (k = 0; k < eq.size(); k++) check("fifo byte", gq[k], eq[k]);
        gq = {};
        eq = {};
    endtask

    initial begin
        seed = 32'h2e4fa033;
        {sys_rst, hold, cmd_valid, cmd_read, wr_valid, rx_ready} = 6'h21;
        cmd_addr = 7'h00;
        cmd_len = 4'h0;
        wr_data = 8'h00;
        st = 4'h5;
        address_select_pin = 1'b0;
        bad_count = 0;
        n_tests = 0;
        cyc = 0;
        repeat (5) @(posedge mclk);
        #2;
        sys_rst = 1'b0;
        repeat (8) @(posedge mclk);
        #2;
        for (i = 0; i < 3; i++) begin
            st = 4'($random(seed));
            address_select_pin = i[0];
            repeat (4) @(posedge mclk);
            #2;
            wr(dev, 4'h8, 1'b1, 1'b0);
            wr(dev, 4'h2, 1'b1, 1'b0);
            rdp(8'($random(seed)), 4'(i + 1));
            wr(dev ^ 7'(1 << i), 4'h1, 1'b0, 1'b1);
        end
        wr(7'h00, 4'h2, 1'b1, 1'b0);
        check("general call", {7'h00, gcall_seen}, 8'h01);
        wr(dev, 4'h9, 1'b1, 1'b0);
        check("general call", {7'h00, gcall_seen}, 8'h00);
        wr(dev, 4'h0, 1'b1, 1'b0);
        cmpq();
        hold = 1'b1;
        repeat (4) wr(dev, 4'h8, 1'b1, 1'b0);
        wr(dev, 4'h1, 1'b1, 1'b1);
        check("fifo held", {7'h00, rx_valid}, 8'h01);
        hold = 1'b0;
        cmpq();
        conclude();
    end
endmodule // two_wire_serial_slave_test

// ### testbench/tws_checker.sv
// Checker of the two-wire bus joining the master and slave ends.
// Assumes plain carrier signals and a single mclk domain.
`timescale 1ns/1ps
module tws_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_host_out,
    input wire logic sda_host_oe_n,
    input wire logic sda_dev_out,
    input wire logic sda_dev_oe_n,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic [3:0] bcnt;
    logic [3:0] bidx;
    logic start_ev;
    logic stop_ev;
    logic rise;

    assign start_ev = scl && scl_q && sda_q && !sda;
    assign stop_ev = scl && scl_q && !sda_q && sda;
    assign rise = scl && !scl_q;

    // Bit and byte position in the datagram
    always_ff @(posedge mclk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (sys_rst || start_ev || stop_ev) begin
            bcnt <= 4'h0;
            bidx <= 4'h0;
        end else if (rise) begin
            bcnt <= (bcnt == 4'h8) ? 4'h0 : bcnt + 4'h1;
            bidx <= (bcnt == 4'h8) ? bidx + 4'h1 : bidx;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_rst_release;
        $fell(sys_rst) |-> sda_dev_oe_n && scl_oe_n && sda_host_oe_n;
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("lines held after reset");
    property p_open_drain;
        scl_out == 1'b0 && sda_host_out == 1'b0 && sda_dev_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_dev_low;
        $changed(sda_dev_oe_n) |-> !scl;
    endproperty
    a_dev_low: assert property (p_dev_low) else $error("device data moved with clock high");
    property p_dev_hold;
        $rose(scl) |-> $stable(sda_dev_oe_n) [*8];
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("device data moved at clock rise");
    property p_addr_quiet;
        bidx == 4'h0 && bcnt != 4'h8 |-> sda_dev_oe_n;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address");
    property p_ack_held;
        $fell(sda_dev_oe_n) && bcnt == 4'h8 |-> !sda throughout (##[1:40] $rose(scl));
    endproperty
    a_ack_held: assert property (p_ack_held) else $error("ack not held to clock rise");
    property p_nack_quiet;
        rise && bcnt == 4'h8 && sda |-> sda_dev_oe_n throughout (##[1:300] stop_ev);
    endproperty
    a_nack_quiet: assert property (p_nack_quiet) else $error("device drove after nack");
    property p_stop_free;
        stop_ev |=> sda_dev_oe_n [*8];
    endproperty
    a_stop_free: assert property (p_stop_free) else $error("device drove after stop");

    c_start: cover property (start_ev);
    c_ack: cover property ($fell(sda_dev_oe_n) && bcnt == 4'h8);
    c_read_end: cover property (rise && bcnt == 4'h8 && sda && bidx != 4'h0);
endmodule // tws_checker
